// *** design/bldc_pkg.sv ***
// shared constants and state type for the sensorless motor control logic
package bldc_pkg;
    localparam int DUTY_W = 7;
    localparam int CMD_W = 8;
    localparam int STEP_W = 3;
    localparam logic [DUTY_W-1:0] DUTY_ZERO = 7'h00;
    localparam logic [DUTY_W-1:0] DUTY_FULL = 7'h7f;
    localparam logic [CMD_W-1:0] CMD_LO = 8'h20;
    localparam logic [CMD_W-1:0] CMD_HI = 8'h9f;
    localparam logic [CMD_W-1:0] CMD_STARTUP = 8'h33;
    localparam logic [STEP_W-1:0] STEP_FIRST = 3'h0;
    localparam logic [STEP_W-1:0] STEP_LAST = 3'h5;
    localparam logic [1:0] SHIFT_BOTH_HI = 2'h0;
    localparam logic [1:0] SHIFT_HI_ONLY = 2'h1;
    localparam logic [1:0] SHIFT_LO_ONLY = 2'h2;
    localparam logic [1:0] SHIFT_NONE_HI = 2'h3;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXCITE,
        ST_FORCED,
        ST_SENSORLESS
    } motor_state_e;
endpackage

// *** design/bldc_startup_ctrl.sv ***
// startup sequencing, duty conversion, position and speed pulses for bldc
`timescale 1ns/1ps

module bldc_startup_ctrl #(
    parameter int FORCED_DIV_BASE = 65536,
    parameter int DIV_W = 20
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [2:0] phaseCmp,
    input wire logic [bldc_pkg::CMD_W-1:0] speedCommandIn,
    input wire logic excitationTimerIn,
    input wire logic forcedRateSelLo,
    input wire logic forcedRateSelHi,
    input wire logic abnormalIn,
    output logic positionOut,
    output logic pwmOut,
    output logic excitationStartN,
    output logic [bldc_pkg::STEP_W-1:0] commStep,
    output logic sensorlessMode,
    output logic speedPulseOut,
    output logic speedPulseOe
);
    import bldc_pkg::*;

    localparam logic [DIV_W-1:0] DIV_BASE = DIV_W'(FORCED_DIV_BASE);
    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);

    motor_state_e state_q, state_d;
    logic position_q, posPrev_q;
    logic [DUTY_W-1:0] duty_q;
    logic [DIV_W-1:0] divCnt_q;
    logic [STEP_W-1:0] step_q;
    logic pulseTgl_q, pulseOe_q, excN_q;

    pwm_if pwmBus ();

    pwm_gen u_pwm (
        .clk(clk),
        .resetn(resetn),
        .pwm(pwmBus)
    );

    wire majority = (phaseCmp[0] & phaseCmp[1]) | (phaseCmp[1] & phaseCmp[2])
        | (phaseCmp[0] & phaseCmp[2]);
    wire posEdge = position_q ^ posPrev_q;

    wire cmdBelow = speedCommandIn < CMD_LO;
    wire cmdAbove = speedCommandIn > CMD_HI;
    // linear region, upper threshold chosen so the span fits 7 bits
    wire [CMD_W-1:0] cmdOffset = speedCommandIn - CMD_LO;
    wire [DUTY_W-1:0] duty_d = cmdBelow ? DUTY_ZERO :
        cmdAbove ? DUTY_FULL : cmdOffset[DUTY_W-1:0];

    wire [1:0] rateShift = (forcedRateSelHi & forcedRateSelLo) ?
        SHIFT_BOTH_HI :
        forcedRateSelHi ? SHIFT_HI_ONLY :
        forcedRateSelLo ? SHIFT_LO_ONLY : SHIFT_NONE_HI;
    // each lower setting doubles the step interval
    wire [DIV_W-1:0] divLimit = (DIV_BASE << rateShift) - DIV_ONE;
    // six steps per electrical cycle, so one step each time the divider reaches divLimit
    wire forcedTick = (state_q == ST_FORCED) && (divCnt_q == divLimit);
    wire cmdRun = speedCommandIn >= CMD_STARTUP;
    wire stepAdv = forcedTick || (state_q == ST_SENSORLESS && posEdge);

    // sequencing: idle, align, forced, sensorless
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: if (cmdRun) begin
                state_d = ST_EXCITE;
            end
            ST_EXCITE: if (excitationTimerIn) begin
                state_d = ST_FORCED;
            end
            // first back-emf edge hands over to sensorless drive
            ST_FORCED: if (posEdge) begin
                state_d = ST_SENSORLESS;
            end
            ST_SENSORLESS: state_d = ST_SENSORLESS;
        endcase
        if (!cmdRun) begin
            state_d = ST_IDLE;
        end
    end

    // pulse pin held low
    // registered state, so the pin is never released on the handover edge
    wire holdLow = (state_q != ST_SENSORLESS) || abnormalIn;

    // state, position and duty registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            position_q <= 1'b0;
            posPrev_q <= 1'b0;
            duty_q <= DUTY_ZERO;
            excN_q <= 1'b1;
        end else begin
            state_q <= state_d;
            position_q <= majority;
            posPrev_q <= position_q;
            duty_q <= duty_d;
            excN_q <= (state_d == ST_IDLE);
        end
    end

    // forced step divider, restarts outside forced mode
    always_ff @(posedge clk) begin
        if (!resetn || state_q != ST_FORCED || forcedTick) begin
            divCnt_q <= '0;
        end else begin
            divCnt_q <= divCnt_q + DIV_ONE;
        end
    end

    // commutation step, wraps after the sixth
    always_ff @(posedge clk) begin
        if (!resetn || state_q == ST_IDLE) begin
            step_q <= STEP_FIRST;
        end else if (stepAdv) begin
            step_q <= (step_q == STEP_LAST) ? STEP_FIRST : step_q + 3'h1;
        end
    end

    // toggle per edge, six edges make three pulses
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pulseTgl_q <= 1'b0;
            pulseOe_q <= 1'b1;
        end else begin
            // toggle restarts low so a new run begins with the pin held
            pulseTgl_q <= (state_q != ST_SENSORLESS) ? 1'b0 :
                posEdge ? ~pulseTgl_q : pulseTgl_q;
            pulseOe_q <= holdLow | ~pulseTgl_q;
        end
    end

    assign pwmBus.duty = duty_q;
    assign pwmOut = pwmBus.pwmOn;
    assign positionOut = position_q;
    assign excitationStartN = excN_q;
    assign commStep = step_q;
    assign sensorlessMode = (state_q == ST_SENSORLESS);
    // open drain: the pin is only ever pulled low
    assign speedPulseOut = 1'b0;
    assign speedPulseOe = pulseOe_q;

    property p_majority;
        @(posedge clk) disable iff (!resetn)
        ##1 positionOut == (($past(phaseCmp[0]) + $past(phaseCmp[1])
            + $past(phaseCmp[2])) >= 2'd2);
    endproperty
    a_majority: assert property (p_majority)
        else $error("position is not phase majority");

    property p_duty_clamp;
        @(posedge clk) disable iff (!resetn)
        (cmdBelow |=> duty_q == DUTY_ZERO) and
        (cmdAbove |=> duty_q == DUTY_FULL);
    endproperty
    a_duty_clamp: assert property (p_duty_clamp)
        else $error("duty clamp wrong");

    property p_duty_linear;
        @(posedge clk) disable iff (!resetn)
        (!cmdBelow && !cmdAbove && $past(resetn)
            && $past(!cmdBelow && !cmdAbove)
            && speedCommandIn > $past(speedCommandIn))
        |=> duty_q > $past(duty_q);
    endproperty
    a_duty_linear: assert property (p_duty_linear)
        else $error("duty not following command");

    property p_excite;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_IDLE && cmdRun) |=> !excitationStartN
            && state_q == ST_EXCITE;
    endproperty
    a_excite: assert property (p_excite)
        else $error("excitation not started");

    property p_forced;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_EXCITE && excitationTimerIn && cmdRun)
            |=> state_q == ST_FORCED ##1 divCnt_q == DIV_ONE || !cmdRun
            || state_q != ST_FORCED;
    endproperty
    a_forced: assert property (p_forced)
        else $error("forced commutation not entered");

    property p_hold_low;
        @(posedge clk) disable iff (!resetn)
        (state_q != ST_SENSORLESS || abnormalIn) |-> ##1 speedPulseOe;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("speed pulse released during startup");

    property p_pulse;
        @(posedge clk) disable iff (!resetn)
        (state_q == ST_SENSORLESS && posEdge)
            |=> pulseTgl_q != $past(pulseTgl_q);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("speed pulse missed an edge");

    property p_rate_base;
        @(posedge clk) disable iff (!resetn)
        forcedTick |-> divCnt_q == divLimit ##1 divCnt_q == '0;
    endproperty
    a_rate_base: assert property (p_rate_base)
        else $error("forced step interval wrong");

    property p_rate_slow;
        @(posedge clk) disable iff (!resetn)
        !(forcedRateSelHi && forcedRateSelLo)
            |-> divLimit > DIV_BASE - DIV_ONE;
    endproperty
    a_rate_slow: assert property (p_rate_slow)
        else $error("slow rate not slower");

    c_sensorless: cover property (@(posedge clk) disable iff (!resetn)
        state_q == ST_FORCED ##1 state_q == ST_SENSORLESS);
    c_forced_step: cover property (@(posedge clk) disable iff (!resetn)
        forcedTick);
    c_abort: cover property (@(posedge clk) disable iff (!resetn)
        state_q == ST_EXCITE ##1 state_q == ST_IDLE);
endmodule

// *** design/pwm_gen.sv ***
// free running 7-bit pwm counter compared against the held duty code
`timescale 1ns/1ps
module pwm_gen (
    input wire logic clk,
    input wire logic resetn,
    pwm_if.gen pwm
);
    import bldc_pkg::*;

    logic [DUTY_W-1:0] cnt_q;
    logic pwmOn_q;
    wire pwmOn_d = cnt_q < pwm.duty;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cnt_q <= DUTY_ZERO;
            pwmOn_q <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 7'h01;
            pwmOn_q <= pwmOn_d;
        end
    end

    assign pwm.pwmOn = pwmOn_q;

    property p_pwm_zero;
        @(posedge clk) disable iff (!resetn)
        pwm.duty == DUTY_ZERO |=> !pwm.pwmOn;
    endproperty
    a_pwm_zero: assert property (p_pwm_zero)
        else $error("pwm high with zero duty");

    property p_pwm_full;
        @(posedge clk) disable iff (!resetn)
        (pwm.duty == DUTY_FULL && cnt_q == DUTY_FULL) |=> !pwm.pwmOn
            ##1 (pwm.pwmOn || $past(pwm.duty) != DUTY_FULL);
    endproperty
    a_pwm_full: assert property (p_pwm_full)
        else $error("full duty is not 127 of 128");

    c_pwm_mid: cover property (@(posedge clk) disable iff (!resetn)
        pwm.duty == 7'h40 ##1 $fell(pwm.pwmOn));
endmodule

// *** design/pwm_if.sv ***
// duty value and pwm level passed between the controller and the pwm counter
`timescale 1ns/1ps
interface pwm_if;
    logic [bldc_pkg::DUTY_W-1:0] duty;
    logic pwmOn;
    modport ctrl (output duty, input pwmOn);
    modport gen (input duty, output pwmOn);
endinterface

// *** tb/motor_model.sv ***
// back-emf polarity model of the three motor windings
`timescale 1ns/1ps
module motor_model #(
    parameter int STEP_CYC = 20
) (
    input wire logic clk,
    input wire logic spin,
    input wire logic [2:0] manual,
    output logic [2:0] phaseCmp
);
    logic [2:0] rotor_q;
    int cnt_q;
    logic [2:0] emf;
    // six-step polarity table: the majority flips on every step
    assign emf = (rotor_q == 3'h0) ? 3'h1 : (rotor_q == 3'h1) ? 3'h3 :
        (rotor_q == 3'h2) ? 3'h2 : (rotor_q == 3'h3) ? 3'h6 :
        (rotor_q == 3'h4) ? 3'h4 : 3'h5;
    // a stopped rotor has no back-emf, so the bench sets the levels
    assign phaseCmp = spin ? emf : manual;
    // rotor turns at a fixed speed, independent of the drive
    always_ff @(posedge clk) begin
        if (!spin || cnt_q == STEP_CYC - 1) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
        if (!spin) begin
            rotor_q <= 3'h0;
        end else if (cnt_q == STEP_CYC - 1) begin
            rotor_q <= (rotor_q == 3'h5) ? 3'h0 : rotor_q + 3'h1;
        end
    end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the sensorless startup and speed logic
`timescale 1ns/1ps
module tb_top;
    import bldc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] manual = 3'h0;
    logic spin = 1'b0;
    logic [CMD_W-1:0] cmd = 8'h00;
    logic timer = 1'b0;
    logic selLo = 1'b1;
    logic selHi = 1'b1;
    logic abnormal = 1'b0;
    logic [2:0] phaseCmp;
    logic positionOut, pwmOut, startN, sensorless, pulse, pulseOe;
    logic [STEP_W-1:0] step;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    // small divider base keeps forced steps short
    bldc_startup_ctrl #(.FORCED_DIV_BASE(8)) i_dut (.clk(clk),
        .resetn(resetn), .phaseCmp(phaseCmp), .speedCommandIn(cmd),
        .excitationTimerIn(timer), .forcedRateSelLo(selLo),
        .forcedRateSelHi(selHi), .abnormalIn(abnormal),
        .positionOut(positionOut), .pwmOut(pwmOut),
        .excitationStartN(startN), .commStep(step),
        .sensorlessMode(sensorless), .speedPulseOut(pulse),
        .speedPulseOe(pulseOe));
    motor_model i_motor (.clk(clk), .spin(spin), .manual(manual),
        .phaseCmp(phaseCmp));
    initial begin
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic hang();
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        final_report();
    endtask
    // waits are bounded so a stuck design still reaches the report
    task automatic waitStep();
        logic [STEP_W-1:0] s;
        s = step;
        for (int i = 0; i < 300; i++) begin
            tick(1);
            if (step !== s) return;
        end
        hang();
    endtask
    task automatic waitOe(input logic v);
        for (int i = 0; i < 300; i++) begin
            if (pulseOe === v) return;
            tick(1);
        end
        hang();
    endtask
    task automatic tMajority();
        for (int p = 0; p < 8; p++) begin
            manual = p[2:0];
            tick(1);
            chk(positionOut, (p[0] + p[1] + p[2]) >= 2);
        end
    endtask
    task automatic tDuty();
        logic [7:0] tbl [8] = '{8'h00, 8'h1f, 8'h20, 8'h21, 8'h60,
            8'h9f, 8'ha0, 8'hff};
        int hi;
        logic [6:0] e;
        for (int i = 0; i < 8; i++) begin
            cmd = tbl[i];
            tick(4);
            hi = 0;
            for (int c = 0; c < 128; c++) begin
                tick(1);
                hi += (pwmOut === 1'b1);
            end
            e = (cmd < CMD_LO) ? DUTY_ZERO : (cmd > CMD_HI) ? DUTY_FULL :
                7'(cmd - CMD_LO);
            chk(16'(hi), 16'(e));
        end
        cmd = 8'h00;
        tick(2);
    endtask
    task automatic tForced();
        int t0;
        for (int k = 0; k < 4; k++) begin
            {selHi, selLo} = 2'(3 - k);
            cmd = CMD_STARTUP - 8'h01;
            tick(3);
            chk(startN, 1'b1);
            cmd = CMD_STARTUP;
            tick(1);
            chk(startN, 1'b0);
            tick(30);
            chk(step, STEP_FIRST);
            timer = 1'b1;
            waitStep();
            t0 = cyc;
            waitStep();
            chk(16'(cyc - t0), 16'(8 << k));
            chk(pulseOe, 1'b1);
            cmd = 8'h00;
            timer = 1'b0;
            tick(2);
            chk(startN, 1'b1);
        end
    endtask
    task automatic tSensorless();
        int falls;
        logic prev;
        cmd = 8'h80;
        timer = 1'b1;
        tick(4);
        spin = 1'b1;
        tick(6);
        chk(sensorless, 1'b1);
        // sync on a pulse edge, then count falling edges of the enable over 220 cycles
        waitOe(1'b1);
        waitOe(1'b0);
        falls = 0;
        for (int c = 0; c < 220; c++) begin
            prev = pulseOe;
            tick(1);
            falls += (prev === 1'b1 && pulseOe === 1'b0);
        end
        chk(16'(falls), 16'h5);
        abnormal = 1'b1;
        tick(2);
        falls = 0;
        for (int c = 0; c < 100; c++) begin
            tick(1);
            falls += (pulseOe !== 1'b1);
        end
        chk(16'(falls), 16'h0);
        abnormal = 1'b0;
        spin = 1'b0;
        cmd = 8'h00;
        tick(3);
        chk(startN, 1'b1);
    endtask
    initial begin
        tick(12);
        resetn = 1'b1;
        tick(1);
        chk({positionOut, startN, step, pulseOe, pulse}, 16'h22);
        tMajority();
        tDuty();
        tForced();
        tSensorless();
        final_report();
    end
endmodule
